// *** host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   // Clock
   input  wire logic       clock_i,
   // Command bus
   output logic            write_strobe_o,
   output logic            data_command_select_o,
   output logic [7:0]      bus_data_o
);
   initial
   begin
      write_strobe_o = 1'b0;
      data_command_select_o = 1'b0;
      bus_data_o = 8'h00;
   end
   // One byte per strobe; a video port user drives this as serial path
   task automatic wr(input logic dcs, input logic [7:0] d);
      @(posedge clock_i);
      write_strobe_o <= 1'b1;
      data_command_select_o <= dcs;
      bus_data_o <= d;
      @(posedge clock_i);
      write_strobe_o <= 1'b0;
      // Released bus must not keep showing the last byte
      bus_data_o <= ~d;
   endtask
endmodule
`default_nettype wire

// *** idle_and_pixel_format_cmds.sv ***
// Behaviour
// RULE1 - Command 39h with no parameter enters idle reduced-colour state.
// RULE2 - Idle shows only each component's top bit, eight colours.
// RULE3 - Idle top bits red green blue map to the eight primaries.
// RULE4 - Command 3Ah then one data byte stores the pixel format.
// RULE5 - Bits 6:4 video port format, bits 2:0 host format, 7,3 zero.
// RULE6 - Field 101 means 16 bpp, 110 means 18 bpp, rest reserved.
// RULE7 - Format field of an unused interface is ignored.
// RULE8 - Fields reset to 110 on hardware reset; software reset keeps them.
// RULE9 - Video port use requires the host to use a serial command path.
// RULE10 - Command 38h leaves idle, returning to full colour.
// RULE11 - Outside idle all component bits are shown.
// RULE12 - Idle enter while idle changes nothing.
`timescale 1ns/1ps
`default_nettype none
`include "idle_pixfmt_regs.svh"
module idle_and_pixel_format_cmds
(
   // Clock, reset, enable
   input  wire logic                        clock_i,
   input  wire logic                        reset_n_i,
   input  wire logic                        enable_i,
   input  wire logic                        soft_reset_i,
   // Command bus, one write per enabled clock cycle in which the write strobe is high and soft reset is low
   input  wire logic                        write_strobe_i,
   input  wire logic                        data_command_select_i,
   input  wire logic [7:0]                  bus_data_i,
   // Interface usage
   input  wire logic                        video_port_used_i,
   input  wire logic                        host_bus_used_i,
   // Pixel path
   input  wire logic [17:0]                 pixel_i,
   output logic      [17:0]                 pixel_o,
   // Status
   output logic                             idle_o,
   output logic      [2:0]                  video_port_pixel_format_o,
   output logic      [2:0]                  host_bus_pixel_format_o,
   output idle_pixfmt_pkg::pixel_depth_t    video_depth_o,
   output idle_pixfmt_pkg::pixel_depth_t    host_depth_o
);
   import idle_pixfmt_pkg::*;

   function automatic pixel_depth_t decode_depth(input logic [2:0] f);
      case (f)
         `FMT_16BPP: decode_depth = FMT_BPP16; // RULE6
         `FMT_18BPP: decode_depth = FMT_BPP18; // RULE6
         default:    decode_depth = FMT_RESERVED;
      endcase
   endfunction

   decode_state_t state;
   decode_state_t next_state;
   logic          idle;
   logic          next_idle;
   logic [2:0]    video_fmt;
   logic [2:0]    next_video_fmt;
   logic [2:0]    host_fmt;
   logic [2:0]    next_host_fmt;

   always_comb
   begin
      next_state     = state;
      next_idle      = idle;
      next_video_fmt = video_fmt;
      next_host_fmt  = host_fmt;
      if (soft_reset_i)
      begin
         // Formats survive a software reset
         next_idle  = 1'b0; // RULE8
         next_state = ST_CMD;
      end
      else if (write_strobe_i)
      begin
         if (!data_command_select_i)
         begin
            next_state = ST_CMD;
            case (bus_data_i)
               `IDLE_ENTER_CODE:   next_idle = 1'b1; // RULE1 RULE12
               `IDLE_EXIT_CODE:    next_idle = 1'b0; // RULE10
               `PIXEL_FORMAT_CODE: next_state = ST_PARAM; // RULE4
               default:            next_state = ST_CMD;
            endcase
         end
         else if (state == ST_PARAM)
         begin
            // Extra data bytes after the first are dropped
            next_state = ST_CMD;
            if (video_port_used_i)
               next_video_fmt =
                  bus_data_i[`VIDEO_FMT_MSB:`VIDEO_FMT_LSB]; // RULE4 RULE5 RULE7
            if (host_bus_used_i)
               next_host_fmt =
                  bus_data_i[`HOST_FMT_MSB:`HOST_FMT_LSB]; // RULE5 RULE7
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state     <= ST_CMD;
         idle      <= 1'b0;
         video_fmt <= `FMT_RESET; // RULE8
         host_fmt  <= `FMT_RESET; // RULE8
      end
      else if (enable_i)
      begin
         state     <= next_state;
         idle      <= next_idle;
         video_fmt <= next_video_fmt;
         host_fmt  <= next_host_fmt;
      end
   end

   assign idle_o                    = idle;
   assign video_port_pixel_format_o = video_fmt;
   assign host_bus_pixel_format_o   = host_fmt;
   assign video_depth_o             = decode_depth(video_fmt);
   assign host_depth_o              = decode_depth(host_fmt);

   idle_colour_map u_map
   (
      .idle_i  (idle),
      .pixel_i (pixel_i),
      .pixel_o (pixel_o)
   );

   sequence s_fmt_cmd;
      enable_i && write_strobe_i && !data_command_select_i
         && bus_data_i == `PIXEL_FORMAT_CODE && !soft_reset_i;
   endsequence
   sequence s_fmt_param;
      enable_i && write_strobe_i && data_command_select_i && !soft_reset_i;
   endsequence
   // A byte-per-strobe host leaves one quiet cycle between the two bytes
   sequence s_quiet;
      !enable_i || (!write_strobe_i && !soft_reset_i);
   endsequence
   sequence s_fmt_pair;
      (s_fmt_cmd ##1 s_fmt_param)
         or (s_fmt_cmd ##1 s_quiet ##1 s_fmt_param);
   endsequence

   property p_idle_enter;
      @(posedge clock_i) disable iff (!reset_n_i)
      enable_i && !soft_reset_i && write_strobe_i && !data_command_select_i
         && bus_data_i == `IDLE_ENTER_CODE |=> idle;
   endproperty
   a_idle_enter: assert property (p_idle_enter) // RULE1
      else $error("idle not entered");

   property p_idle_exit;
      @(posedge clock_i) disable iff (!reset_n_i)
      enable_i && !soft_reset_i && write_strobe_i && !data_command_select_i
         && bus_data_i == `IDLE_EXIT_CODE |=> !idle;
   endproperty
   a_idle_exit: assert property (p_idle_exit) // RULE10
      else $error("idle not left");

   property p_idle_map;
      @(posedge clock_i) disable iff (!reset_n_i)
      idle |-> pixel_o[17:12] == {6{pixel_i[17]}}
         && pixel_o[11:6] == {6{pixel_i[11]}}
         && pixel_o[5:0] == {6{pixel_i[5]}};
   endproperty
   a_idle_map: assert property (p_idle_map) // RULE2 RULE3
      else $error("idle colour wrong");

   property p_full_colour;
      @(posedge clock_i) disable iff (!reset_n_i)
      !idle |-> pixel_o == pixel_i;
   endproperty
   a_full_colour: assert property (p_full_colour) // RULE11
      else $error("full colour wrong");

   property p_fmt_store;
      @(posedge clock_i) disable iff (!reset_n_i)
      s_fmt_pair ##0 host_bus_used_i
         |=> host_fmt == $past(bus_data_i[`HOST_FMT_MSB:`HOST_FMT_LSB]);
   endproperty
   a_fmt_store: assert property (p_fmt_store) // RULE4 RULE5
      else $error("format not stored");

   property p_video_store;
      @(posedge clock_i) disable iff (!reset_n_i)
      s_fmt_pair ##0 video_port_used_i
         |=> video_fmt == $past(bus_data_i[`VIDEO_FMT_MSB:`VIDEO_FMT_LSB]);
   endproperty
   a_video_store: assert property (p_video_store) // RULE4 RULE5
      else $error("video format not stored");

   property p_unused_kept;
      @(posedge clock_i) disable iff (!reset_n_i)
      !host_bus_used_i |=> host_fmt == $past(host_fmt);
   endproperty
   a_unused_kept: assert property (p_unused_kept) // RULE7
      else $error("unused field changed");

   property p_video_unused_kept;
      @(posedge clock_i) disable iff (!reset_n_i)
      !video_port_used_i |=> video_fmt == $past(video_fmt);
   endproperty
   a_video_unused_kept: assert property (p_video_unused_kept) // RULE7
      else $error("unused video field changed");

   property p_soft_keep;
      @(posedge clock_i) disable iff (!reset_n_i)
      enable_i && soft_reset_i |=> video_fmt == $past(video_fmt)
         && host_fmt == $past(host_fmt) && !idle;
   endproperty
   a_soft_keep: assert property (p_soft_keep) // RULE8
      else $error("soft reset touched format");

   property p_depth;
      @(posedge clock_i) disable iff (!reset_n_i)
      host_fmt == `FMT_18BPP |-> host_depth_o == FMT_BPP18;
   endproperty
   a_depth: assert property (p_depth) // RULE6
      else $error("depth decode wrong");

   property p_reenter;
      @(posedge clock_i) disable iff (!reset_n_i)
      idle && write_strobe_i && !data_command_select_i && !soft_reset_i
         && bus_data_i == `IDLE_ENTER_CODE |=> idle;
   endproperty
   a_reenter: assert property (p_reenter) // RULE12
      else $error("re-enter disturbed idle");
endmodule
`default_nettype wire

// *** idle_colour_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module idle_colour_map
(
   // Control
   input  wire logic        idle_i,
   // Pixel in from frame memory and out to the panel
   input  wire logic [17:0] pixel_i,
   output logic      [17:0] pixel_o
);
   genvar c;
   generate
      for (c = 0; c < 3; c = c + 1)
      begin : g_comp
         // Top bit replicated gives full-scale primaries
         assign pixel_o[c*6 +: 6] = idle_i ? {6{pixel_i[c*6+5]}}
                                           : pixel_i[c*6 +: 6]; // RULE2 RULE3 RULE11
      end
   endgenerate
endmodule
`default_nettype wire

// *** idle_pixfmt_pkg.sv ***
package idle_pixfmt_pkg;
   typedef enum logic [1:0]
   {
      FMT_RESERVED = 2'b00,
      FMT_BPP16    = 2'b01,
      FMT_BPP18    = 2'b10
   } pixel_depth_t;
   typedef enum logic [0:0]
   {
      ST_CMD   = 1'b0,
      ST_PARAM = 1'b1
   } decode_state_t;
endpackage

// *** idle_pixfmt_regs.svh ***
`ifndef IDLE_PIXFMT_REGS_SVH
`define IDLE_PIXFMT_REGS_SVH
`define IDLE_EXIT_CODE      8'h38
`define IDLE_ENTER_CODE     8'h39
`define PIXEL_FORMAT_CODE   8'h3a
`define PIXEL_FORMAT_RESET  8'h66
`define VIDEO_FMT_MSB       6
`define VIDEO_FMT_LSB       4
`define HOST_FMT_MSB        2
`define HOST_FMT_LSB        0
`define FMT_16BPP           3'h5
`define FMT_18BPP           3'h6
`define FMT_RESET           3'h6
`endif

// *** tb_idle_and_pixel_format_cmds.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "idle_pixfmt_regs.svh"
module tb_idle_and_pixel_format_cmds;
   import idle_pixfmt_pkg::*;
   logic         clock_i, reset_n_i, enable_i, soft_reset_i;
   logic         vid_used, host_used, strobe, dcs, idle_o;
   logic [7:0]   bdata;
   logic [17:0]  pixel_i, pixel_o;
   logic [2:0]   vfmt, hfmt;
   pixel_depth_t vdep, hdep;
   int           n_mismatch = 0;
   int           n_checks = 0;
   host_model u_host (.clock_i(clock_i), .write_strobe_o(strobe),
      .data_command_select_o(dcs), .bus_data_o(bdata));
   idle_and_pixel_format_cmds u_dut (.clock_i(clock_i),
      .reset_n_i(reset_n_i), .enable_i(enable_i),
      .soft_reset_i(soft_reset_i), .write_strobe_i(strobe),
      .data_command_select_i(dcs), .bus_data_i(bdata),
      .video_port_used_i(vid_used), .host_bus_used_i(host_used),
      .pixel_i(pixel_i), .pixel_o(pixel_o), .idle_o(idle_o),
      .video_port_pixel_format_o(vfmt), .host_bus_pixel_format_o(hfmt),
      .video_depth_o(vdep), .host_depth_o(hdep));
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic settle;
      @(posedge clock_i);
      #1;
   endtask
   task automatic fmt(input logic [7:0] p);
      u_host.wr(1'b0, `PIXEL_FORMAT_CODE);
      u_host.wr(1'b1, p);
      settle;
   endtask
   function automatic logic [17:0] dep(input logic [2:0] c);
      return (c == `FMT_16BPP) ? 18'h1 : (c == `FMT_18BPP) ? 18'h2 : 18'h0;
   endfunction
   task automatic wrap_up;
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   // About 106 cycles of tests; generous margin
   initial
   begin
      #20000;
      n_mismatch++;
      wrap_up;
   end
   initial
   begin
      reset_n_i = 1'b0;
      enable_i = 1'b1;
      soft_reset_i = 1'b0;
      vid_used = 1'b1;
      host_used = 1'b1;
      pixel_i = 18'h2b5a6;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      #1;
      chk(vfmt, 3'h6); chk(hfmt, 3'h6); chk(vdep, 18'h2);
      chk(idle_o, 1'b0); chk(pixel_o, pixel_i);
      // Top and middle bits set on purpose; they must be dropped
      for (int c = 0; c < 8; c++)
      begin
         fmt({1'b1, c[2:0], 1'b1, ~c[2:0]});
         chk(vfmt, c[2:0]); chk(hfmt, 3'(~c[2:0]));
         chk(vdep, dep(c[2:0])); chk(hdep, dep(~c[2:0]));
      end
      u_host.wr(1'b1, 8'h55);
      settle;
      chk(vfmt, 3'h7);
      fmt(8'h56);
      u_host.wr(1'b1, 8'h11);
      settle;
      chk(vfmt, 3'h5); chk(hfmt, 3'h6);
      // An unknown command cancels a pending format command
      u_host.wr(1'b0, `PIXEL_FORMAT_CODE);
      u_host.wr(1'b0, 8'h00);
      u_host.wr(1'b1, 8'h11);
      settle;
      chk(vfmt, 3'h5); chk(hfmt, 3'h6);
      @(posedge clock_i) vid_used <= 1'b0;
      fmt(8'h65);
      chk(vfmt, 3'h5); chk(hfmt, 3'h5);
      @(posedge clock_i) {vid_used, host_used} <= 2'b10;
      fmt(8'h66);
      chk(vfmt, 3'h6); chk(hfmt, 3'h5);
      @(posedge clock_i) host_used <= 1'b1;
      u_host.wr(1'b0, `IDLE_ENTER_CODE);
      settle;
      chk(idle_o, 1'b1);
      for (int k = 0; k < 8; k++)
      begin
         @(posedge clock_i) pixel_i <= {k[2], 5'h0a, k[1], 5'h15, k[0], 5'h1f};
         #1;
         chk(pixel_o, {{6{k[2]}}, {6{k[1]}}, {6{k[0]}}});
      end
      u_host.wr(1'b0, `IDLE_ENTER_CODE);
      settle;
      chk(idle_o, 1'b1); chk(pixel_o, 18'h3ffff);
      @(posedge clock_i) enable_i <= 1'b0;
      u_host.wr(1'b0, `IDLE_EXIT_CODE);
      settle;
      chk(idle_o, 1'b1);
      @(posedge clock_i) enable_i <= 1'b1;
      u_host.wr(1'b0, `IDLE_EXIT_CODE);
      settle;
      chk(idle_o, 1'b0); chk(pixel_o, pixel_i);
      u_host.wr(1'b0, `IDLE_ENTER_CODE);
      @(posedge clock_i) soft_reset_i <= 1'b1;
      @(posedge clock_i) soft_reset_i <= 1'b0;
      settle;
      chk(idle_o, 1'b0); chk(vfmt, 3'h6); chk(hfmt, 3'h5);
      @(posedge clock_i) reset_n_i <= 1'b0;
      @(posedge clock_i) reset_n_i <= 1'b1;
      #1;
      chk(hfmt, 3'h6); chk(vfmt, 3'h6);
      chk(idle_o, 1'b0);
      wrap_up;
   end
endmodule
`default_nettype wire
